/* File: src/pms_sequencer.v */
// Power mode sequencer: five operating modes, hibernate entry and wake handling
`timescale 1ns/1ps
`default_nettype none
`include "pms_defs.vh"

// ==========================================================================
// Overview of operation
// - After reset: full-on, PLL enabled unbypassed, both clocks running, core powered.
// - Active mode: PLL bypassed, and enabled unless its off bit is set; clocks run at input clock.
// - Sleep mode: core clock gated, PLL and system clock keep running.
// - Enabled wakeup in sleep: bypass clear goes full-on, set goes active.
// - No system DMA grants into level-one memory while sleeping.
// - Deep sleep: PLL off, both clocks gated, no internal resource access.
// - Deep sleep exits only on RTC interrupt (active) or reset (full-on).
// - Writing frequency field zero enters hibernate: core supply, clocks, PLL off.
// - That same write drives both external wake outputs low.
// - Hibernate three-states the pins under pin_oe_n; wake and SDRAM hold outputs stay driven.
// - Enabled network, PHY, RTC wake or reset leaves hibernate via reset sequence.
// - External wake outputs rise to signal a hibernate wake event.
// - Regulator control register survives hibernate; other state is lost.
// - Regulator bit holds SDRAM in self-refresh through hibernate and reset.
// - Wake outputs are active high: high requests power-up.

module pms_sequencer #(
  parameter WAKE_W       = `PMS_WAKE_W,
  parameter RESET_CYCLES = `PMS_RESET_CYCLES
) (
  input  wire              clk,                     // 50 MHz system clock
  input  wire              rst_n,                   // Power-on reset, async, active low
  input  wire              pll_wr,                  // Write strobe, PLL control
  input  wire [15:0]       pll_wdata,               // Write data, PLL control
  input  wire              vr_wr,                   // Write strobe, regulator control
  input  wire [15:0]       vr_wdata,                // Write data, regulator control
  input  wire [WAKE_W-1:0] wake_irq,                // Async wakeup requests
  input  wire [WAKE_W-1:0] wakeup_enable_regs,      // Wakeup enables, same clock
  input  wire              rtc_wake,                // Async RTC wake, active high
  input  wire              eth_usb_wake,            // Async network/USB wake, active high
  input  wire              phy_wake_pin_n,          // Async PHY interrupt pin, active low
  input  wire              reset_pin_n,             // Async reset pin, active low
  input  wire              dma_l1_req,              // System DMA request into L1
  output reg  [4:0]        op_mode,                 // Current mode, one-hot
  output reg               pll_enable,              // PLL powered and running
  output reg               pll_bypassed,            // Clocks taken from input clock
  output reg               core_clock_signal_en,    // Core clock gate enable
  output reg               sys_clk_en,              // System clock gate enable
  output reg               core_supply_on,          // Core supply on
  output reg               periph_access_en,        // Internal resource access allowed
  output reg               pin_oe_n,                // Pin drivers, low while driving
  output reg               dma_l1_gnt,              // DMA grant into L1
  output reg               external_wake_out_a,     // Regulator wake, high = power-up
  output reg               external_wake_out_b,     // Regulator wake, high = power-up
  output reg               sdram_self_refresh_hold, // Keep SDRAM in self-refresh
  output reg               hw_reset,                // Hardware reset sequence active
  output reg  [15:0]       pll_control_reg,         // PLL control readback
  output reg  [15:0]       regulator_control_reg    // Regulator control readback
);

  localparam [4:0] S_FULL  = `PMS_MODE_FULL_ON;
  localparam [4:0] S_ACT   = `PMS_MODE_ACTIVE;
  localparam [4:0] S_SLEEP = `PMS_MODE_SLEEP;
  localparam [4:0] S_DEEP  = `PMS_MODE_DEEP_SLEEP;
  localparam [4:0] S_HIB   = `PMS_MODE_HIBERNATE;
  localparam SW = WAKE_W + 4;

  // ========================================================================
  // Control decode per mode, msb first: pll_en, bypass, core_clock_signal, sclk, pins driven, power
  // Bypass follows the mode alone: active always runs on the input clock
  function [5:0] mode_ctrl;
    input [4:0] m;
    begin
      case (m)
        S_FULL:  mode_ctrl = 6'h2f;
        S_ACT:   mode_ctrl = 6'h3f;
        S_SLEEP: mode_ctrl = 6'h27;
        // Deep sleep keeps only core power and driven pins
        S_DEEP:  mode_ctrl = 6'h03;
        S_HIB:   mode_ctrl = 6'h00;
        // Unknown codes fall back to the safe full-on settings
        default: mode_ctrl = 6'h2f;
      endcase
    end
  endfunction

  // ========================================================================
  // Input synchronisers
  wire [SW-1:0] sync_out;
  wire [WAKE_W-1:0] wake_s;
  wire          rtc_s;
  wire          net_s;
  wire          phy_n_s;
  wire          rstpin_n_s;

  pms_sync #(
    .WIDTH   (SW),
    .RST_VAL ({{WAKE_W{1'b0}}, 4'h3})
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({wake_irq, rtc_wake, eth_usb_wake, phy_wake_pin_n, reset_pin_n}),
    .dout  (sync_out)
  );

  assign wake_s     = sync_out[SW-1:4];
  assign rtc_s      = sync_out[3];
  assign net_s      = sync_out[2];
  assign phy_n_s    = sync_out[1];
  assign rstpin_n_s = sync_out[0];

  // ========================================================================
  // Reset sequence timer
  reg  seq_start;
  wire seq_busy;

  pms_reset_seq #(
    .CYCLES (RESET_CYCLES)
  ) u_rseq (
    .clk   (clk),
    .rst_n (rst_n),
    .start (seq_start),
    .busy  (seq_busy)
  );

  // ========================================================================
  // State
  reg [4:0]  mode_r;
  reg [4:0]  mode_nxt;
  reg [15:0] pll_r;
  reg [15:0] pll_nxt;
  reg [15:0] vr_r;
  reg [15:0] vr_nxt;
  reg        hib_seq_r;
  reg        hib_seq_nxt;
  reg        wake_any;
  reg        hib_wake;
  reg        run_req;
  wire [5:0] ctrl_nxt;

  assign ctrl_nxt = mode_ctrl(mode_nxt);

  // ========================================================================
  // Decoded controls for the mode about to be entered
  wire ctl_pll_en;
  wire ctl_bypass;
  wire ctl_core_clock_signal;
  wire ctl_sclk;
  wire ctl_pins;
  wire ctl_power;
  wire nx_act;
  wire nx_hib;
  wire nx_run;

  assign ctl_pll_en = ctrl_nxt[5];
  assign ctl_bypass = ctrl_nxt[4];
  assign ctl_core_clock_signal   = ctrl_nxt[3];
  assign ctl_sclk   = ctrl_nxt[2];
  assign ctl_pins   = ctrl_nxt[1];
  assign ctl_power  = ctrl_nxt[0];
  assign nx_act     = (mode_nxt == S_ACT);
  assign nx_hib     = (mode_nxt == S_HIB);
  // Only full-on and active may carry L1 DMA; sleep and below refuse it
  assign nx_run     = (mode_nxt == S_FULL) | (mode_nxt == S_ACT);

  // ========================================================================
  // Next-state logic
  always @* begin
    mode_nxt    = mode_r;
    pll_nxt     = pll_r;
    vr_nxt      = vr_r;
    seq_start   = 1'b0;
    hib_seq_nxt = hib_seq_r & seq_busy;
    wake_any = |(wake_s & wakeup_enable_regs);
    hib_wake = (net_s & vr_r[`PMS_VR_EN_NET_BIT])
             | (~phy_n_s & vr_r[`PMS_VR_EN_PHY_BIT])
             | (rtc_s & vr_r[`PMS_VR_EN_RTC_BIT]);
    run_req = 1'b0;
    // Reset pin wins over every request, a same-cycle wake included
    if (!rstpin_n_s) begin
      mode_nxt  = S_FULL;
      pll_nxt   = `PMS_PLL_RESET;
      seq_start = 1'b1;
      if (mode_r == S_HIB) begin
        vr_nxt[`PMS_VR_REGULATOR_FIELD_A_MSB:`PMS_VR_REGULATOR_FIELD_A_LSB] = `PMS_REGULATOR_FIELD_A_RESTORE;
        hib_seq_nxt = 1'b1;
      end
    end else begin
      case (mode_r)
        S_FULL, S_ACT: begin
          run_req = ~seq_busy;
        end
        S_SLEEP: begin
          // bypass bit picks the wake target
          if (wake_any) begin
            mode_nxt = pll_r[`PMS_PLL_BYPASS_BIT] ? S_ACT : S_FULL;
          end
        end
        S_DEEP: begin
          if (rtc_s) begin
            mode_nxt = S_ACT;
          end
        end
        S_HIB: begin
          // wake starts the hardware reset sequence
          if (hib_wake) begin
            mode_nxt    = S_FULL;
            pll_nxt     = `PMS_PLL_RESET;
            seq_start   = 1'b1;
            hib_seq_nxt = 1'b1;
            vr_nxt[`PMS_VR_REGULATOR_FIELD_A_MSB:`PMS_VR_REGULATOR_FIELD_A_LSB] = `PMS_REGULATOR_FIELD_A_RESTORE;
          end
        end
        default: begin
          mode_nxt = S_FULL;
        end
      endcase
    end
    // Software requests only while running and not in a reset sequence
    if (run_req) begin
      if (vr_wr) begin
        vr_nxt = vr_wdata;
      end
      if (vr_wr && vr_wdata[`PMS_VR_REGULATOR_FIELD_A_MSB:`PMS_VR_REGULATOR_FIELD_A_LSB] == `PMS_REGULATOR_FIELD_A_HIBERNATE) begin
        mode_nxt = S_HIB;
      end else if (pll_wr) begin
        pll_nxt = pll_wdata & `PMS_PLL_KEEP_MASK;
        // PLL control input must be back on
        if (pll_wdata[`PMS_PLL_SLEEP_BIT] && !pll_wdata[`PMS_PLL_OFF_BIT]) begin
          mode_nxt = S_SLEEP;
        end else if (pll_wdata[`PMS_PLL_DEEP_BIT]) begin
          mode_nxt = S_DEEP;
        end else if (pll_wdata[`PMS_PLL_BYPASS_BIT]) begin
          mode_nxt = S_ACT;
        end else if (!pll_wdata[`PMS_PLL_OFF_BIT]) begin
          mode_nxt = S_FULL;
        end
      end
    end
  end

  // ========================================================================
  // Registers and registered outputs
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r                  <= S_FULL;
      op_mode                 <= S_FULL;
      pll_r                   <= `PMS_PLL_RESET;
      pll_control_reg         <= `PMS_PLL_RESET;
      vr_r                    <= `PMS_VR_RESET;
      regulator_control_reg   <= `PMS_VR_RESET;
      hib_seq_r               <= 1'b0;
      pll_enable              <= 1'b1;
      pll_bypassed            <= 1'b0;
      core_clock_signal_en    <= 1'b1;
      sys_clk_en              <= 1'b1;
      core_supply_on          <= 1'b1;
      periph_access_en        <= 1'b1;
      pin_oe_n                <= 1'b0;
      dma_l1_gnt              <= 1'b0;
      external_wake_out_a     <= 1'b1;
      external_wake_out_b     <= 1'b1;
      sdram_self_refresh_hold <= 1'b0;
      hw_reset                <= 1'b0;
    end else begin
      // state moves only through the next-state logic
      mode_r                <= mode_nxt;
      op_mode               <= mode_nxt;
      pll_r                 <= pll_nxt;
      pll_control_reg       <= pll_nxt;
      // kept through hibernate; the exit reset sets only field A back to 3
      vr_r                  <= vr_nxt;
      regulator_control_reg <= vr_nxt;
      hib_seq_r             <= hib_seq_nxt;
      pll_enable            <= ctl_pll_en & ~(nx_act & pll_nxt[`PMS_PLL_OFF_BIT]);
      pll_bypassed          <= ctl_bypass;
      core_clock_signal_en  <= ctl_core_clock_signal;
      sys_clk_en            <= ctl_sclk;
      core_supply_on        <= ctl_power;
      // no internal access with clocks stopped
      periph_access_en      <= ctl_sclk;
      pin_oe_n              <= ~ctl_pins;
      // no L1 DMA grant while asleep
      dma_l1_gnt            <= dma_l1_req & nx_run & ~seq_start & ~seq_busy;
      // low only in hibernate, high on wake
      external_wake_out_a   <= ~nx_hib;
      external_wake_out_b   <= ~nx_hib;
      // hold self-refresh through hibernate and the reset after it
      sdram_self_refresh_hold <= vr_nxt[`PMS_VR_SDRAM_BIT] & (nx_hib | hib_seq_nxt);
      hw_reset              <= seq_start | seq_busy;
    end
  end

endmodule
`default_nettype wire

/* File: src/pms_defs.vh */
// Constants for the power mode sequencer: field positions, reset values, counts
`ifndef PMS_DEFS_VH
`define PMS_DEFS_VH

// ==========================================================================
// Operating modes, one-hot
`define PMS_MODE_W          5
`define PMS_MODE_FULL_ON    5'h01
`define PMS_MODE_ACTIVE     5'h02
`define PMS_MODE_SLEEP      5'h04
`define PMS_MODE_DEEP_SLEEP 5'h08
`define PMS_MODE_HIBERNATE  5'h10

// ==========================================================================
// PLL control register fields
`define PMS_REG_W            16
`define PMS_PLL_OFF_BIT      1
`define PMS_PLL_SLEEP_BIT    3
`define PMS_PLL_DEEP_BIT     5
`define PMS_PLL_BYPASS_BIT   8
`define PMS_PLL_KEEP_MASK    16'h0102
`define PMS_PLL_RESET        16'h0000

// ==========================================================================
// Regulator control register fields
`define PMS_VR_REGULATOR_FIELD_A_MSB      1
`define PMS_VR_REGULATOR_FIELD_A_LSB      0
`define PMS_REGULATOR_FIELD_A_HIBERNATE   2'h0
`define PMS_REGULATOR_FIELD_A_RESTORE     2'h3
`define PMS_VR_EN_NET_BIT    8
`define PMS_VR_EN_PHY_BIT    9
`define PMS_VR_EN_RTC_BIT    10
`define PMS_VR_SDRAM_BIT     15
`define PMS_VR_RESET         16'h0003

// ==========================================================================
// Sizes and timing counts
`define PMS_WAKE_W           8
`define PMS_RESET_CYCLES     16

`endif

/* File: src/pms_sync.v */
// Two flip-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
`default_nettype none

module pms_sync #(
  parameter WIDTH   = 4,
  parameter RST_VAL = 4'h0
) (
  input  wire             clk,    // System clock
  input  wire             rst_n,  // Async reset, active low
  input  wire [WIDTH-1:0] din,    // Asynchronous inputs
  output wire [WIDTH-1:0] dout    // Synchronised levels
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // ========================================================================
  // First stage feeds only the second
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  assign dout = sync_r;

endmodule
`default_nettype wire

/* File: src/pms_reset_seq.v */
// Hardware reset sequence timer, restartable
`timescale 1ns/1ps
`default_nettype none

module pms_reset_seq #(
  parameter CYCLES = 16
) (
  input  wire clk,    // System clock
  input  wire rst_n,  // Async reset, active low
  input  wire start,  // Pulse or level: (re)starts the sequence
  output reg  busy    // High while the sequence runs
);

  localparam integer  CW     = $clog2(CYCLES + 1);
  localparam integer  LAST_I = CYCLES - 1;
  localparam [CW-1:0] LAST   = LAST_I[CW-1:0];

  reg [CW-1:0] cnt_r;

  // ========================================================================
  // Count down; a new start while busy restarts the full length
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= {CW{1'b0}};
      busy  <= 1'b0;
    end else if (start) begin
      cnt_r <= LAST;
      busy  <= 1'b1;
    end else if (busy) begin
      if (cnt_r == {CW{1'b0}}) begin
        busy <= 1'b0;
      end else begin
        cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule
`default_nettype wire

/* File: verification/pms_seq_chk.sv */
// Port checker for the power mode sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pms_defs.vh"
module pms_seq_chk #(
  parameter WAKE_W       = 8,
  parameter RESET_CYCLES = 16
) (
  input wire logic              clk,                     // Clock
  input wire logic              rst_n,                   // Reset
  input wire logic              pll_wr,                  // PLL write
  input wire logic [15:0]       pll_wdata,               // PLL data
  input wire logic              vr_wr,                   // VR write
  input wire logic [15:0]       vr_wdata,                // VR data
  input wire logic [WAKE_W-1:0] wake_irq,                // Wakeups
  input wire logic [WAKE_W-1:0] wakeup_enable_regs,      // Enables
  input wire logic              rtc_wake,                // RTC wake
  input wire logic              eth_usb_wake,            // Net wake
  input wire logic              phy_wake_pin_n,          // PHY pin
  input wire logic              reset_pin_n,             // Reset pin
  input wire logic              dma_l1_req,              // DMA req
  input wire logic [4:0]        op_mode,                 // Mode
  input wire logic              pll_enable,              // PLL on
  input wire logic              pll_bypassed,            // Bypass
  input wire logic              core_clock_signal_en,    // Core clk
  input wire logic              sys_clk_en,              // Sys clk
  input wire logic              core_supply_on,          // Supply
  input wire logic              periph_access_en,        // Access
  input wire logic              pin_oe_n,                // Pins
  input wire logic              dma_l1_gnt,              // DMA gnt
  input wire logic              external_wake_out_a,     // Wake a
  input wire logic              external_wake_out_b,     // Wake b
  input wire logic              sdram_self_refresh_hold, // SDRAM
  input wire logic              hw_reset,                // Reset seq
  input wire logic [15:0]       pll_control_reg,         // PLL reg
  input wire logic [15:0]       regulator_control_reg    // VR reg
);
  // ====
  // Reset pin history: a recent pin pulse may override any request
  logic [3:0] rpin_r;
  wire        quiet = reset_pin_n & (&rpin_r);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) rpin_r <= 4'hf;
    else rpin_r <= {rpin_r[2:0], reset_pin_n};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ====
  full_on_a: assert property (op_mode == `PMS_MODE_FULL_ON |-> pll_enable && !pll_bypassed
    && core_clock_signal_en && sys_clk_en && core_supply_on) else $error("full-on settings wrong");
  active_byp_a: assert property (op_mode == `PMS_MODE_ACTIVE |-> pll_bypassed
    && core_clock_signal_en && sys_clk_en) else $error("active settings wrong");
  sleep_gate_a: assert property (op_mode == `PMS_MODE_SLEEP |->
    !core_clock_signal_en && sys_clk_en && pll_enable) else $error("sleep gating wrong");
  sleep_dma_a: assert property (op_mode[2] && $past(op_mode[2]) |-> !dma_l1_gnt)
    else $error("DMA granted in sleep");
  deep_gate_a: assert property (op_mode == `PMS_MODE_DEEP_SLEEP |->
    !(pll_enable | core_clock_signal_en | sys_clk_en | periph_access_en)) else $error("deep gating wrong");
  hib_pins_a: assert property (op_mode == `PMS_MODE_HIBERNATE |-> pin_oe_n && !pll_enable
    && !external_wake_out_a && !external_wake_out_b && !core_supply_on) else $error("hibernate outputs wrong");
  hib_entry_a: assert property (vr_wr && vr_wdata[1:0] == 2'h0 && (op_mode[0] | op_mode[1])
    && !hw_reset && quiet && !$past(op_mode[4]) |=> op_mode[4]) else $error("hibernate not entered");
  wake_exit_a: assert property (op_mode[4] && eth_usb_wake && regulator_control_reg[8] |->
    ##[1:4] (op_mode[0] && hw_reset && external_wake_out_a && external_wake_out_b))
    else $error("hibernate wake missed");
  sdram_hold_a: assert property (sdram_self_refresh_hold |-> regulator_control_reg[15]
    && (op_mode[4] || hw_reset)) else $error("SDRAM hold out of place");
  mode_keep_a: assert property (op_mode[1] && !pll_wr && !vr_wr && quiet && !hw_reset
    |=> op_mode[1]) else $error("mode left without cause");
endmodule
bind pms_sequencer pms_seq_chk #(.WAKE_W(WAKE_W), .RESET_CYCLES(RESET_CYCLES)) i_pms_seq_chk (.*);
`default_nettype wire

/* File: verification/pms_wake_model.sv */
// External regulator and wake source model
`timescale 1ns/1ps
`default_nettype none
module pms_wake_model (
  input  wire logic       wake_a,         // Wake output a
  input  wire logic       wake_b,         // Wake output b
  input  wire logic [2:0] fire,           // Commands: net, PHY, RTC
  output var logic        eth_usb_wake,   // Network wake
  output var logic        phy_wake_pin_n, // PHY pin, pulled up
  output var logic        rtc_wake,       // RTC wake
  output var logic        vdd_core_up     // Regulator output on
);
  always @* begin
    eth_usb_wake = fire[0];
    phy_wake_pin_n = !fire[1];
    rtc_wake = fire[2];
  end
  always @* vdd_core_up = wake_a | wake_b;
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the power mode sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 0, rst_n = 0, pll_wr = 0, vr_wr = 0, reset_pin_n = 1, dma_l1_req = 0;
  logic [15:0] pll_wdata = 0, vr_wdata = 0;
  logic [7:0]  wake_irq = 0, wakeup_enable_regs = 8'h01;
  logic [2:0]  fire = 0;
  wire         eth_usb_wake, phy_wake_pin_n, rtc_wake, vdd_core_up, pll_enable, pll_bypassed;
  wire         core_clock_signal_en, sys_clk_en, core_supply_on, periph_access_en, pin_oe_n;
  wire         dma_l1_gnt, external_wake_out_a, external_wake_out_b;
  wire         sdram_self_refresh_hold, hw_reset;
  wire [4:0]   op_mode;
  wire [15:0]  pll_control_reg, regulator_control_reg;
  wire [15:0]  mode16 = {11'h0, op_mode};
  wire [15:0]  st = {4'h0, pll_enable, pll_bypassed, core_clock_signal_en, sys_clk_en,
                     core_supply_on, periph_access_en, pin_oe_n, dma_l1_gnt, external_wake_out_a,
                     external_wake_out_b, sdram_self_refresh_hold, hw_reset};
  int          failures = 0;
  int          compares = 0;
  pms_sequencer #(.RESET_CYCLES(4)) i_pms_sequencer (.*);
  pms_wake_model i_pms_wake_model (.wake_a(external_wake_out_a), .wake_b(external_wake_out_b),
    .fire(fire), .eth_usb_wake(eth_usb_wake), .phy_wake_pin_n(phy_wake_pin_n),
    .rtc_wake(rtc_wake), .vdd_core_up(vdd_core_up));
  always #10 clk = ~clk;
  // ====
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic vr, input logic [15:0] d);
    @(posedge clk);
    pll_wr <= !vr;
    vr_wr <= vr;
    pll_wdata <= d;
    vr_wdata <= d;
    @(posedge clk);
    pll_wr <= 0;
    vr_wr <= 0;
    @(posedge clk);
    #1;
  endtask
  task automatic wait_mode(input logic [15:0] m, input int n);
    for (int i = 0; i < n && mode16 !== m; i++) begin
      @(posedge clk);
      #1;
    end
    cmp("op_mode", m, mode16);
  endtask
  task automatic idle();
    #1;
    for (int i = 0; i < 40 && hw_reset !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    cmp("hw_reset", 0, {15'h0, hw_reset});
  endtask
  task automatic end_of_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ====
  task automatic t_modes();
    cmp("status", 16'h0bcc, st);
    cmp("vr_reg", 16'h0003, regulator_control_reg);
    wr(0, 16'h0100);
    cmp("status", 16'h0fcc, st);
    cmp("pll_reg", 16'h0100, pll_control_reg);
    wr(0, 16'h0102);
    cmp("status", 16'h07cc, st);
    wr(0, 16'h0002);
    cmp("op_mode", 16'h0002, mode16);
    cmp("status", 16'h07cc, st);
    wr(0, 16'h0100);
    wr(0, 16'h0000);
    cmp("op_mode", 16'h0001, mode16);
  endtask
  task automatic t_sleep();
    for (int bp = 0; bp < 2; bp++) begin
      @(posedge clk) dma_l1_req <= 1;
      wr(0, bp ? 16'h0108 : 16'h0008);
      cmp("status", 16'h09cc, st & 16'hfbff);
      wr(1, 16'h0000);
      cmp("vr_reg", 16'h0003, regulator_control_reg);
      @(posedge clk) wake_irq <= 8'h02;
      repeat (6) @(posedge clk);
      #1 cmp("op_mode", 16'h0004, mode16);
      @(posedge clk) wake_irq <= 8'h03;
      wait_mode(bp ? 16'h0002 : 16'h0001, 8);
      @(posedge clk) wake_irq <= 0;
      #1 cmp("dma_gnt", 1, {15'h0, dma_l1_gnt});
      @(posedge clk) dma_l1_req <= 0;
      wr(0, 16'h0000);
    end
  endtask
  task automatic t_deep();
    for (int src = 0; src < 2; src++) begin
      wr(0, 16'h0120);
      cmp("status", 16'h008c, st & 16'hfbff);
      @(posedge clk) wake_irq <= 8'h01;
      repeat (6) @(posedge clk);
      #1 cmp("op_mode", 16'h0008, mode16);
      @(posedge clk) wake_irq <= 0;
      if (src) reset_pin_n <= 0;
      else fire <= 3'h4;
      wait_mode(src ? 16'h0001 : 16'h0002, 8);
      @(posedge clk) reset_pin_n <= 1;
      fire <= 0;
      idle();
      wr(0, 16'h0000);
    end
  endtask
  task automatic t_hib();
    for (int src = 0; src < 4; src++) begin
      wr(1, 16'h8700);
      cmp("op_mode", 16'h0010, mode16);
      cmp("status", 16'h0022, st);
      cmp("supply", 0, {15'h0, vdd_core_up});
      @(posedge clk);
      if (src == 3) reset_pin_n <= 0;
      else fire <= 3'h1 << src;
      wait_mode(16'h0001, 8);
      cmp("status", 16'h0bcf, st);
      cmp("vr_reg", 16'h8703, regulator_control_reg);
      cmp("supply", 1, {15'h0, vdd_core_up});
      @(posedge clk) reset_pin_n <= 1;
      fire <= 0;
      idle();
      cmp("status", 16'h0bcc, st);
    end
  endtask
  // ====
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    #1;
    t_modes();
    t_sleep();
    t_deep();
    t_hib();
    end_of_test();
  end
  initial begin
    #400000;
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
